/* pbc_consts.vh */
`ifndef PBC_CONSTS_VH
`define PBC_CONSTS_VH

// ----------------------------------------
// register addresses, reset values and masks
// ----------------------------------------
`define PBC_ADDR_W 32
`define PBC_PORT_B_ADDR 32'hFFFF8390
`define PBC_PORT_C_ADDR 32'hFFFF8392
`define PBC_PORT_B_RESET 16'h0000
`define PBC_PORT_C_RESET 16'h0000
`define PBC_PORT_B_MASK 16'h03FF
`define PBC_PORT_B_SMALL_MASK 16'h03FC

// ----------------------------------------
// access sizes and operating modes
// ----------------------------------------
`define PBC_SIZE_BYTE 2'h0
`define PBC_SIZE_HALF 2'h1
`define PBC_SIZE_WORD 2'h2
`define PBC_MODE_EXT0 2'h0
`define PBC_MODE_EXT1 2'h1
`define PBC_MODE_EXT_ROM 2'h2
`define PBC_MODE_SINGLE 2'h3

`endif

/* pbc_lane.v */
`timescale 1ns/1ns
`include "pbc_consts.vh"

// merges a bus write into one 16-bit data register
module pbc_lane (
  // access
  input wire [1:0] size,
  input wire byte_sel,
  input wire [31:0] wdata,
  // register
  input wire [15:0] cur,
  input wire [15:0] keep_mask,
  output reg [15:0] nxt
);
  reg [15:0] raw;

  always @* begin
    raw = cur;
    if (size == `PBC_SIZE_BYTE) begin
      if (byte_sel == 1'b0) begin
        raw = {wdata[7:0], cur[7:0]};
      end else begin
        raw = {cur[15:8], wdata[7:0]};
      end
    end else begin
      raw = wdata[15:0];
    end
    nxt = raw & keep_mask;
  end
endmodule

/* pbc_pin_mux.v */
`timescale 1ns/1ns
`include "pbc_consts.vh"

// per-pin output selection and readback
module pbc_pin_mux #(
  parameter WIDTH = 16
) (
  // control
  input wire [WIDTH-1:0] dir,
  input wire [WIDTH-1:0] alt_sel,
  input wire [WIDTH-1:0] alt_out,
  input wire [WIDTH-1:0] alt_oe_n,
  // data
  input wire [WIDTH-1:0] data,
  input wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] pin_out,
  output wire [WIDTH-1:0] pin_oe_n,
  output wire [WIDTH-1:0] rd_val
);
  assign pin_out = (alt_sel & alt_out) | (~alt_sel & data);
  assign pin_oe_n = (alt_sel & alt_oe_n) | (~alt_sel & ~dir);
  assign rd_val = (dir & data) | (~dir & pin_in);
endmodule

/* pbc_ports.v */
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns
`include "pbc_consts.vh"

module pbc_ports #(
  parameter SMALL_VARIANT = 0
) (
  // clock and power-on reset
  input wire clk,
  input wire reset,
  // register port
  input wire [31:0] addr,
  input wire [1:0] size,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  // mode and direction
  input wire [1:0] mode,
  input wire [9:0] port_b_direction,
  input wire [15:0] port_c_direction,
  input wire [9:0] port_b_alt_sel,
  input wire [9:0] port_b_alt_out,
  input wire [9:0] port_b_alt_oe_n,
  input wire [15:0] port_c_addr_sel,
  input wire [15:0] ext_addr,
  // pins
  input wire [9:0] port_b_in,
  output wire [9:0] port_b_out,
  output wire [9:0] port_b_oe_n,
  input wire [15:0] port_c_in,
  output wire [15:0] port_c_out,
  output wire [15:0] port_c_oe_n
);
  // ----------------------------------------
  // decode
  // ----------------------------------------
  reg [15:0] port_b_pin_data_r;
  reg [15:0] port_c_pin_data_r;
  wire [15:0] b_nxt;
  wire [15:0] c_nxt;
  wire [15:0] b_keep;
  wire [9:0] b_rd;
  wire [15:0] c_rd;
  wire [15:0] c_sel;
  wire [31:0] word_addr;
  wire hit_b_lane;
  wire hit_c_lane;
  wire hit_word;
  wire wr_b;
  wire wr_c;
  reg [31:0] rdata_nxt;

  assign word_addr = {addr[31:2], 2'b00};
  assign hit_word = (word_addr == `PBC_PORT_B_ADDR) && (size == `PBC_SIZE_WORD);
  assign hit_b_lane = (size != `PBC_SIZE_WORD) && ({addr[31:1], 1'b0} == `PBC_PORT_B_ADDR);
  assign hit_c_lane = (size != `PBC_SIZE_WORD) && ({addr[31:1], 1'b0} == `PBC_PORT_C_ADDR);
  assign wr_b = wr && (hit_b_lane || hit_word);
  // small variant keeps the port c pins but no port c register access; its accesses fall off the map
  assign wr_c = wr && (hit_c_lane || hit_word) && (SMALL_VARIANT == 0);
  assign b_keep = (SMALL_VARIANT != 0) ? `PBC_PORT_B_SMALL_MASK : `PBC_PORT_B_MASK;

  // ----------------------------------------
  // write merge
  // ----------------------------------------
  pbc_lane u_lane_b (
    .size(size),
    .byte_sel(addr[0]),
    .wdata(hit_word ? {16'h0000, wdata[31:16]} : wdata),
    .cur(port_b_pin_data_r),
    .keep_mask(b_keep),
    .nxt(b_nxt)
  );

  pbc_lane u_lane_c (
    .size(size),
    .byte_sel(addr[0]),
    .wdata(wdata),
    .cur(port_c_pin_data_r),
    .keep_mask(16'hFFFF),
    .nxt(c_nxt)
  );

  // only the power-on reset reaches here; watchdog and sleep leave it alone
  always @(posedge clk) begin
    if (reset) begin
      port_b_pin_data_r <= `PBC_PORT_B_RESET;
      port_c_pin_data_r <= `PBC_PORT_C_RESET;
    end else begin
      if (wr_b) begin
        port_b_pin_data_r <= b_nxt;
      end
      if (wr_c) begin
        port_c_pin_data_r <= c_nxt;
      end
    end
  end

  // ----------------------------------------
  // pins
  // ----------------------------------------
  pbc_pin_mux #(.WIDTH(10)) u_mux_b (
    .dir(port_b_direction),
    .alt_sel(port_b_alt_sel),
    .alt_out(port_b_alt_out),
    .alt_oe_n(port_b_alt_oe_n),
    .data(port_b_pin_data_r[9:0]),
    .pin_in(port_b_in),
    .pin_out(port_b_out),
    .pin_oe_n(port_b_oe_n),
    .rd_val(b_rd)
  );

  // address function: forced in romless modes, per pin in rom mode, never single chip
  assign c_sel = (mode == `PBC_MODE_EXT0 || mode == `PBC_MODE_EXT1) ? 16'hFFFF :
                 (mode == `PBC_MODE_EXT_ROM) ? port_c_addr_sel : 16'h0000;

  pbc_pin_mux #(.WIDTH(16)) u_mux_c (
    .dir(port_c_direction),
    .alt_sel(c_sel),
    .alt_out(ext_addr),
    .alt_oe_n(16'h0000),
    .data(port_c_pin_data_r),
    .pin_in(port_c_in),
    .pin_out(port_c_out),
    .pin_oe_n(port_c_oe_n),
    .rd_val(c_rd)
  );

  // ----------------------------------------
  // read
  // ----------------------------------------
  always @* begin
    rdata_nxt = 32'h00000000;
    if (rd) begin
      if (hit_word) begin
        rdata_nxt = {6'h00, b_rd & b_keep[9:0], c_rd};
        if (SMALL_VARIANT != 0) begin
          rdata_nxt[15:0] = 16'h0000;
        end
      end else if (hit_b_lane) begin
        rdata_nxt[15:0] = {6'h00, b_rd & b_keep[9:0]};
        if (size == `PBC_SIZE_BYTE) begin
          rdata_nxt = {24'h000000, addr[0] ? rdata_nxt[7:0] : rdata_nxt[15:8]};
        end
      end else if (hit_c_lane && SMALL_VARIANT == 0) begin
        rdata_nxt[15:0] = c_rd;
        if (size == `PBC_SIZE_BYTE) begin
          rdata_nxt = {24'h000000, addr[0] ? c_rd[7:0] : c_rd[15:8]};
        end
      end
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      rdata <= 32'h00000000;
    end else begin
      rdata <= rdata_nxt;
    end
  end
endmodule

/* pbc_ports_checker.sv */
`timescale 1ns/1ns
module pbc_ports_checker (
  // bus
  input wire clk,
  input wire reset,
  input wire [31:0] addr,
  input wire [1:0] size,
  input wire rd,
  input wire [31:0] rdata,
  // pins
  input wire [1:0] mode,
  input wire [9:0] port_b_direction,
  input wire [9:0] port_b_alt_sel,
  input wire [9:0] port_b_in,
  input wire [9:0] port_b_oe_n,
  input wire [15:0] port_c_direction,
  input wire [15:0] port_c_in,
  input wire [15:0] ext_addr,
  input wire [15:0] port_c_out,
  input wire [15:0] port_c_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_rw; rd && addr == 32'hFFFF8390 && size == 2'h2; endsequence
  property p_idle; !rd |=> rdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("rdata set");
  property p_w_hi; s_rw |=> rdata[31:26] == 6'h0; endproperty
  a_w_hi: assert property (p_w_hi) else $error("b high bits");
  property p_b_pin; s_rw |=> ((rdata[25:16] ^ $past(port_b_in)) & ~$past(port_b_direction)) == 10'h0; endproperty
  a_b_pin: assert property (p_b_pin) else $error("b pin read");
  property p_c_pin; s_rw |=> ((rdata[15:0] ^ $past(port_c_in)) & ~$past(port_c_direction)) == 16'h0; endproperty
  a_c_pin: assert property (p_c_pin) else $error("c pin read");
  property p_b_oe; ((port_b_oe_n ^ ~port_b_direction) & ~port_b_alt_sel) == 10'h0; endproperty
  a_b_oe: assert property (p_b_oe) else $error("b enable");
  property p_c_addr; mode < 2'h2 |-> port_c_out == ext_addr; endproperty
  a_c_addr: assert property (p_c_addr) else $error("c addr out");
  property p_c_oe; mode < 2'h2 |-> port_c_oe_n == 16'h0; endproperty
  a_c_oe: assert property (p_c_oe) else $error("c addr enable");
  property p_single; mode == 2'h3 |-> port_c_oe_n == ~port_c_direction; endproperty
  a_single: assert property (p_single) else $error("c enable");
endmodule
bind pbc_ports pbc_ports_checker u_chk (.*);

/* testbench.sv */
`timescale 1ns/1ns
module testbench;
  localparam [31:0] AB = 32'hFFFF8390;
  reg clk = 1'b0;
  reg reset = 1'b1;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg [1:0] size = 2'h2;
  reg [1:0] mode = 2'h3;
  reg [31:0] addr = 32'h0, wdata = 32'h0, w;
  reg [9:0] port_b_direction = 10'h3FF, port_b_alt_sel = 10'h0, port_b_alt_out = 10'h0;
  reg [9:0] port_b_alt_oe_n = 10'h3FF, port_b_in = 10'h0;
  reg [15:0] port_c_direction = 16'hFFFF, port_c_addr_sel = 16'h0, ext_addr = 16'h0, port_c_in = 16'h0;
  wire [31:0] rdata;
  wire [9:0] port_b_out, port_b_oe_n;
  wire [15:0] port_c_out, port_c_oe_n;
  integer seed = 32'hEA42;
  integer n_mismatch = 0;
  integer cmp_count = 0;
  integer i;
  reg [95:0] r;
  pbc_ports u_pbc_ports (.*);
  always #2 clk = ~clk;
  function [15:0] rb(input [15:0] v, input [15:0] dir, input [15:0] pin);
    rb = (v & dir) | (pin & ~dir);
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task bus(input w_n, input [31:0] a, input [1:0] s, input [31:0] v);
    begin
      @(posedge clk);
      wr <= w_n;
      rd <= !w_n;
      addr <= a;
      size <= s;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      @(negedge clk);
    end
  endtask
  task summarize;
    begin
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    #20000;
    n_mismatch = n_mismatch + 1;
    summarize;
  end
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    bus(0, AB, 2'h2, 32'h0);
    chk(rdata, 32'h0);
    for (i = 0; i < 80; i = i + 1) begin
      @(posedge clk);
      r = {$random(seed), $random(seed), $random(seed)};
      w = $random(seed);
      port_b_direction <= r[9:0];
      port_b_in <= r[19:10];
      port_b_alt_sel <= r[29:20] & r[39:30];
      port_c_direction <= r[55:40];
      port_c_in <= r[71:56];
      ext_addr <= r[87:72];
      mode <= r[89:88];
      port_c_addr_sel <= {r[95:90], r[9:0]};
      bus(1, AB, 2'h2, w);
      chk(port_b_out & port_b_direction & ~port_b_alt_sel, w[25:16] & port_b_direction & ~port_b_alt_sel);
      if (mode == 2'h3) chk(port_c_out & port_c_direction, w[15:0] & port_c_direction);
      if (mode == 2'h2) chk(port_c_out, (port_c_addr_sel & ext_addr) | (~port_c_addr_sel & w[15:0]));
      bus(0, AB, 2'h2, 32'h0);
      chk(rdata, {rb(w[31:16] & 16'h03FF, port_b_direction, port_b_in), rb(w[15:0], port_c_direction, port_c_in)});
    end
    $display("random test done");
    port_b_direction <= 10'h3FF;
    port_c_direction <= 16'hFFFF;
    mode <= 2'h3;
    // bytes replicated on every lane so only the address picks the half
    bus(1, AB, 2'h2, 32'h0);
    bus(1, AB, 2'h0, 32'hA5A5A5A5);
    bus(1, AB + 1, 2'h0, 32'h5A5A5A5A);
    bus(1, AB + 3, 2'h0, 32'hC3C3C3C3);
    bus(0, AB, 2'h2, 32'h0);
    chk(rdata, 32'h015A00C3);
    bus(1, AB + 2, 2'h1, 32'h12341234);
    bus(1, 32'hFFFF8394, 2'h2, 32'hFFFFFFFF);
    bus(0, 32'h0, 2'h2, 32'h0);
    chk(rdata, 32'h0);
    bus(0, AB, 2'h2, 32'h0);
    chk(rdata, 32'h015A1234);
    $display("lane test done");
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    bus(0, AB, 2'h2, 32'h0);
    chk(rdata, 32'h0);
    $display("reset test done");
    summarize;
  end
endmodule
